/* verilog/ipdl_link.sv */
// Link-mode DMA interface with its register slave and cable logic.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.

module ipdl_link
    import ipdl_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // Register bus slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Host bus mastering
    output logic               dma_req_o,
    input  wire logic          dma_gnt_i,
    output logic               mem_valid_o,
    output ipdl_mem_req_t      mem_req_o,
    input  wire logic          mem_ack_i,
    input  wire logic [15:0]   mem_rdata_i,
    // Host status and interrupt
    input  wire logic          power_fail_i,
    output logic               irq_o,
    // Cable to the partner
    input  wire ipdl_link_t    link_i,
    output ipdl_link_t         link_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Merges a 16-bit write under the two low byte lanes.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ipdl_link_t    link_s1_r;
    ipdl_link_t    link_s2_r;
    logic          busy_prev_r;
    logic          fn2_prev_r;
    logic          pf_s1_r;
    logic          pf_s2_r;
    logic [15:0]   wc_r;
    logic [15:0]   ba_r;
    logic [15:0]   odr_r;
    logic [2:0]    fn_r;
    logic [1:0]    xba_r;
    logic          ie_r;
    logic          ready_r;
    logic          cycle_r;
    logic          attention_flag_r;
    logic          armed_r;
    logic          burst_r;
    logic          busy_r;
    ipdl_state_t   state_r;
    logic          wb_req;
    logic          wr_ctrl;
    logic          wr_wc;
    logic          wr_ba;
    logic          wr_data;
    logic          go_wr;
    logic          req_edge;
    logic          grant_start;
    logic          hold_start;
    logic          word_done;
    logic          word_count_overflow;
    logic [15:0]   wc_nxt;
    logic [17:0]   addr_nxt;
    logic [15:0]   csr_view;
    logic [15:0]   ctrl_wr;
    logic [15:0]   ba_merge;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Cable and power-fail levels come from another machine, so each passes
    // two flops; the data word is only sampled well after the busy edge.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            link_s1_r <= '0;
            link_s2_r <= '0;
            pf_s1_r   <= 1'b0;
            pf_s2_r   <= 1'b0;
        end else begin
            link_s1_r <= link_i;
            link_s2_r <= link_s1_r;
            pf_s1_r   <= power_fail_i;
            pf_s2_r   <= pf_s1_r;
        end
    end

    // Delayed copies for edge detection on the settled side only.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_prev_r <= 1'b0;
            fn2_prev_r  <= 1'b0;
        end else begin
            busy_prev_r <= link_s2_r.busy;
            fn2_prev_r  <= link_s2_r.fn[1];
        end
    end

    // ------------------------------------------------------------------
    // Bus decode and event terms
    // ------------------------------------------------------------------
    // A request is answered once; the ack flop masks the second cycle.
    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == IPDL_ADR_CTRL);
    assign wr_wc   = wb_req && wb_we_i && (wb_adr_i == IPDL_ADR_WORD_COUNT);
    assign wr_ba   = wb_req && wb_we_i && (wb_adr_i == IPDL_ADR_BUS_ADDR);
    assign wr_data = wb_req && wb_we_i && (wb_adr_i == IPDL_ADR_DATA);
    assign ctrl_wr = merge16(csr_view, wb_dat_i, wb_sel_i);
    assign go_wr   = wr_ctrl && wb_sel_i[0] && ctrl_wr[IPDL_CSR_GO];
    assign ba_merge = merge16(ba_r, wb_dat_i, wb_sel_i);

    // The partner dropping busy is its request for our next cycle.
    assign req_edge    = busy_prev_r && !link_s2_r.busy;
    assign grant_start = (state_r == IPDL_ST_REQ) && dma_gnt_i;
    assign hold_start  = (state_r == IPDL_ST_HOLD) && cycle_r;
    assign word_done   = (state_r == IPDL_ST_XFER) && mem_ack_i;
    assign wc_nxt      = wc_r + IPDL_WC_STEP;
    assign word_count_overflow        = word_done && (wc_nxt == IPDL_RST_WORD);
    assign addr_nxt    = {xba_r, ba_r} + IPDL_ADDR_STEP;

    // Readback of the control register; status bits mirror the partner.
    always_comb begin
        csr_view = '0;
        csr_view[IPDL_CSR_FN_LO +: 3]   = fn_r;
        csr_view[IPDL_CSR_XBA_LO +: 2]  = xba_r;
        csr_view[IPDL_CSR_IE]           = ie_r;
        csr_view[IPDL_CSR_READY]        = ready_r;
        csr_view[IPDL_CSR_CYCLE]        = cycle_r;
        csr_view[IPDL_CSR_STAT_LO +: 3] = link_s2_r.fn;
        csr_view[IPDL_CSR_ATTENTION_FLAG]         = attention_flag_r;
        csr_view[IPDL_CSR_ERROR]        = attention_flag_r;
    end

    // ------------------------------------------------------------------
    // Register bus answer
    // ------------------------------------------------------------------
    // Every address answers in one cycle; unmapped offsets read zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= '0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    IPDL_ADR_WORD_COUNT: wb_dat_o <= {16'h0000, wc_r};
                    IPDL_ADR_BUS_ADDR:   wb_dat_o <= {16'h0000, ba_r};
                    IPDL_ADR_CTRL:       wb_dat_o <= {16'h0000, csr_view};
                    IPDL_ADR_DATA:       wb_dat_o <= {16'h0000, link_s2_r.data};
                    default:             wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Software-owned control fields
    // ------------------------------------------------------------------
    // Direction and transfer style are plain software bits; software keeps
    // them opposite or matched per end as the link setup needs.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fn_r <= IPDL_RST_FN;
            ie_r <= 1'b0;
        end else if (wr_ctrl && wb_sel_i[0]) begin
            fn_r <= ctrl_wr[IPDL_CSR_FN_LO +: 3];
            ie_r <= ctrl_wr[IPDL_CSR_IE];
        end
    end

    // Go alone arms the engine and clears ready but moves no data.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (go_wr) begin
            armed_r <= 1'b1;
        end else if (word_count_overflow) begin
            armed_r <= 1'b0;
        end
    end

    // Ready clears on go; overflow or a partner interrupt request sets it,
    // and a set in the same cycle as go wins so no event is lost.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_r <= IPDL_RST_READY;
        end else if (word_count_overflow || (link_s2_r.fn[1] && !fn2_prev_r)) begin
            ready_r <= 1'b1;
        end else if (go_wr) begin
            ready_r <= 1'b0;
        end
    end

    // Cycle bit: software start with go, partner request edge, cleared as
    // the bus cycle begins; a request edge beats the clear.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cycle_r <= 1'b0;
        end else if (req_edge && armed_r) begin
            cycle_r <= 1'b1;
        end else if (go_wr && wb_sel_i[1] && ctrl_wr[IPDL_CSR_CYCLE]) begin
            cycle_r <= 1'b1;
        end else if (grant_start || hold_start) begin
            cycle_r <= 1'b0;
        end
    end

    // Attention follows the partner's interrupt request or power-low line;
    // a zero write clears it only once both have gone away.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            attention_flag_r <= 1'b0;
        end else if (link_s2_r.fn[1] || link_s2_r.power_low) begin
            attention_flag_r <= 1'b1;
        end else if (wr_ctrl && wb_sel_i[1] && !ctrl_wr[IPDL_CSR_ATTENTION_FLAG]) begin
            attention_flag_r <= 1'b0;
        end
    end

    // Interrupt line is error gated by the enable bit.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= attention_flag_r && ie_r;
        end
    end

    // ------------------------------------------------------------------
    // Word count and bus address
    // ------------------------------------------------------------------
    // The count steps on every word; the cable has no external enable.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wc_r <= IPDL_RST_WORD;
        end else if (word_done) begin
            wc_r <= wc_nxt;
        end else if (wr_wc) begin
            wc_r <= merge16(wc_r, wb_dat_i, wb_sel_i);
        end
    end

    // Addresses stay even so only whole words cross the link; the carry
    // rolls into the two extension bits.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ba_r  <= IPDL_RST_WORD;
            xba_r <= IPDL_RST_XBA;
        end else if (word_done) begin
            ba_r  <= {addr_nxt[15:1], 1'b0};
            xba_r <= addr_nxt[17:16];
        end else begin
            if (wr_ba) begin
                ba_r <= {ba_merge[15:1], 1'b0};
            end
            if (wr_ctrl && wb_sel_i[0]) begin
                xba_r <= ctrl_wr[IPDL_CSR_XBA_LO +: 2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Output data register
    // ------------------------------------------------------------------
    // Software loads it in word mode; the transmitter's fetch loads it in
    // block and burst modes, and the fetch takes precedence.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            odr_r <= IPDL_RST_WORD;
        end else if (word_done && !fn_r[0]) begin
            odr_r <= mem_rdata_i;
        end else if (wr_data) begin
            odr_r <= merge16(odr_r, wb_dat_i, wb_sel_i);
        end
    end

    // ------------------------------------------------------------------
    // DMA sequencer
    // ------------------------------------------------------------------
    // Block mode asks for the bus per word and releases it after; burst
    // mode keeps the request up between words until overflow.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r     <= IPDL_ST_IDLE;
            dma_req_o   <= 1'b0;
            mem_valid_o <= 1'b0;
            mem_req_o   <= '0;
        end else begin
            unique case (state_r)
                IPDL_ST_IDLE: begin
                    if (cycle_r && armed_r) begin
                        dma_req_o <= 1'b1;
                        state_r   <= IPDL_ST_REQ;
                    end
                end
                IPDL_ST_REQ: begin
                    if (dma_gnt_i) begin
                        // Direction bit picks read for sender, write for receiver.
                        mem_valid_o     <= 1'b1;
                        mem_req_o.addr  <= {xba_r, ba_r[15:1], 1'b0};
                        mem_req_o.we    <= fn_r[0];
                        mem_req_o.wdata <= link_s2_r.data;
                        state_r         <= IPDL_ST_XFER;
                    end
                end
                IPDL_ST_XFER: begin
                    if (mem_ack_i) begin
                        mem_valid_o <= 1'b0;
                        if (word_count_overflow) begin
                            dma_req_o <= 1'b0;
                            state_r   <= IPDL_ST_IDLE;
                        end else if (burst_r) begin
                            state_r   <= IPDL_ST_HOLD;
                        end else begin
                            dma_req_o <= 1'b0;
                            state_r   <= IPDL_ST_IDLE;
                        end
                    end
                end
                IPDL_ST_HOLD: begin
                    // Bus stays owned; the next handshake starts the word.
                    if (cycle_r) begin
                        mem_valid_o     <= 1'b1;
                        mem_req_o.addr  <= {xba_r, ba_r[15:1], 1'b0};
                        mem_req_o.we    <= fn_r[0];
                        mem_req_o.wdata <= link_s2_r.data;
                        state_r         <= IPDL_ST_XFER;
                    end
                end
            endcase
        end
    end

    // Burst flop: a cleared style bit at both ends requests burst; it sets on
    // the first granted cycle and clears in the overflow cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burst_r <= 1'b0;
        end else if (word_count_overflow) begin
            burst_r <= 1'b0;
        end else if (grant_start && !link_s2_r.fn[2] && !fn_r[2]) begin
            burst_r <= 1'b1;
        end
    end

    // Busy rises as our cycle starts and falls once the word is moved;
    // the partner reads the fall as its cycle request.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (word_done) begin
            busy_r <= 1'b0;
        end else if (grant_start || hold_start) begin
            busy_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Cable outputs
    // ------------------------------------------------------------------
    // Everything driven to the partner comes from a flop.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            link_o <= '0;
        end else begin
            link_o.busy      <= busy_r;
            link_o.fn        <= fn_r;
            link_o.power_low <= pf_s2_r;
            link_o.data      <= odr_r;
        end
    end

endmodule

/* verilog/ipdl_pkg.sv */
// Shared constants and carrier types of the interprocessor DMA link.
package ipdl_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the register bus
    // ------------------------------------------------------------------
    localparam logic [7:0] IPDL_ADR_WORD_COUNT = 8'h00;
    localparam logic [7:0] IPDL_ADR_BUS_ADDR   = 8'h04;
    localparam logic [7:0] IPDL_ADR_CTRL       = 8'h08;
    localparam logic [7:0] IPDL_ADR_DATA       = 8'h0c;

    // ------------------------------------------------------------------
    // Control and status field positions
    // ------------------------------------------------------------------
    localparam int IPDL_CSR_GO      = 0;
    localparam int IPDL_CSR_FN_LO   = 1;
    localparam int IPDL_CSR_XBA_LO  = 4;
    localparam int IPDL_CSR_IE      = 6;
    localparam int IPDL_CSR_READY   = 7;
    localparam int IPDL_CSR_CYCLE   = 8;
    localparam int IPDL_CSR_STAT_LO = 9;
    localparam int IPDL_CSR_ATTENTION_FLAG    = 13;
    localparam int IPDL_CSR_ERROR   = 15;

    // ------------------------------------------------------------------
    // Values after reset and fixed steps
    // ------------------------------------------------------------------
    localparam logic        IPDL_RST_READY = 1'b1;
    localparam logic [15:0] IPDL_RST_WORD  = 16'h0000;
    localparam logic [2:0]  IPDL_RST_FN    = 3'h0;
    localparam logic [1:0]  IPDL_RST_XBA   = 2'h0;
    localparam logic [17:0] IPDL_ADDR_STEP = 18'h00002;
    localparam logic [15:0] IPDL_WC_STEP   = 16'h0001;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Host memory request issued while the bus is owned.
    typedef struct packed {
        logic [17:0] addr;
        logic        we;
        logic [15:0] wdata;
    } ipdl_mem_req_t;

    // Cable signals seen from either end.
    typedef struct packed {
        logic        busy;
        logic [2:0]  fn;
        logic        power_low;
        logic [15:0] data;
    } ipdl_link_t;

    // DMA sequencer states.
    typedef enum logic [3:0] {
        IPDL_ST_IDLE = 4'b0001,
        IPDL_ST_REQ  = 4'b0010,
        IPDL_ST_XFER = 4'b0100,
        IPDL_ST_HOLD = 4'b1000
    } ipdl_state_t;

endpackage

/* testbench/ipdl_link_properties.sv */
// Port-level assertions for the interprocessor DMA link.
module ipdl_link_properties
    import ipdl_pkg::*;
(
    // Clock, reset and register writes
    input wire logic          clock,
    input wire logic          rst_n,
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic [7:0]    wb_adr_i,
    input wire logic [3:0]    wb_sel_i,
    input wire logic [31:0]   wb_dat_i,
    // Host bus and cable
    input wire logic          dma_req_o,
    input wire logic          dma_gnt_i,
    input wire logic          mem_valid_o,
    input wire ipdl_mem_req_t mem_req_o,
    input wire logic          mem_ack_i,
    input wire ipdl_link_t    link_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Checks on one clock; reset disables them all.
    // ------------------------------------------------------------
    // The master holds the write through the ack edge, so the data seen two edges back is stable.
    wire logic wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                         && (wb_adr_i == IPDL_ADR_CTRL);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_fn_out; wr_ctrl |-> ##2 (link_o.fn == $past(wb_dat_i[3:1], 2)); endproperty
    a_fn_out: assert property (p_fn_out) else $error("function bits not on cable");
    property p_word_align; mem_valid_o |-> !mem_req_o.addr[0]; endproperty
    a_word_align: assert property (p_word_align) else $error("odd memory address");
    property p_dir_we; mem_valid_o |-> (mem_req_o.we == link_o.fn[0]); endproperty
    a_dir_we: assert property (p_dir_we) else $error("access kind against direction");
    property p_block_release; mem_valid_o && mem_ack_i && link_o.fn[2] |=> !dma_req_o; endproperty
    a_block_release: assert property (p_block_release) else $error("bus kept in block");
    property p_hold_bus; mem_valid_o |-> dma_req_o; endproperty
    a_hold_bus: assert property (p_hold_bus) else $error("access without bus");
    property p_drop_after_ack; $fell(dma_req_o) |-> $past(mem_ack_i); endproperty
    a_drop_after_ack: assert property (p_drop_after_ack) else $error("bus dropped early");
    property p_grant_first; $rose(mem_valid_o) |-> $past(dma_gnt_i) && $past(dma_req_o); endproperty
    a_grant_first: assert property (p_grant_first) else $error("access before grant");
    property p_busy_fall;
        $fell(link_o.busy) |-> $past(mem_ack_i) || $past(mem_ack_i, 2) || $past(mem_ack_i, 3);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell without a word");
endmodule

bind ipdl_link ipdl_link_properties u_chk (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .dma_req_o, .dma_gnt_i, .mem_valid_o, .mem_req_o,
    .mem_ack_i, .link_o);

/* testbench/ipdl_peer.sv */
// Behavioural companion interface at the far end of the cable.
module ipdl_peer
    import ipdl_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Settings from the bench
    input  wire logic [2:0] fn,
    input  wire logic       power_low,
    input  wire logic [3:0] lat,
    input  wire logic       kick,
    // Cable
    input  wire ipdl_link_t from_dut,
    output ipdl_link_t      to_dut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       seen_r;
    logic [3:0] cnt_r;
    // Each word takes lat cycles after the far busy falls; kick is a transmitter's first start.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seen_r <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            seen_r <= from_dut.busy;
            if (kick || (seen_r && !from_dut.busy))
                cnt_r <= lat;
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
        end
    end
    // Busy falling again is the cycle request back to the transmitter.
    assign to_dut.busy = (cnt_r != 4'h0);
    assign to_dut.fn = fn;
    assign to_dut.power_low = power_low;
    assign to_dut.data = 16'h5a3c;
endmodule

/* testbench/ipdl_link_test.sv */
// Self-checking bench for the interprocessor DMA link.
module ipdl_link_test
    import ipdl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clock = 1'b0;
    logic          rst_n = 1'b0;
    logic          wb_cyc_i = 1'b0;
    logic          wb_stb_i = 1'b0;
    logic          wb_we_i = 1'b0;
    logic [7:0]    wb_adr_i = 8'h00;
    logic [31:0]   wb_dat_i = 32'h0;
    logic [31:0]   wb_dat_o;
    logic          wb_ack_o, dma_req_o, mem_valid_o, irq_o;
    ipdl_mem_req_t mem_req_o;
    logic          dma_gnt_i = 1'b0;
    logic          mem_ack_i = 1'b0;
    logic [15:0]   mem_rdata_i = 16'h0000;
    logic          power_fail_i = 1'b0;
    logic          peer_pl = 1'b0;
    logic [2:0]    peer_fn = 3'h0;
    logic [3:0]    peer_lat = 4'h1;
    logic          peer_kick = 1'b0;
    ipdl_link_t    link_i, link_o;
    int            fail_count = 0;
    int            n_checks = 0;
    int            n_rises = 0;
    logic [15:0]   q;

    ipdl_link u_ipdl_link (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o, .dma_req_o, .dma_gnt_i,
        .mem_valid_o, .mem_req_o, .mem_ack_i, .mem_rdata_i, .power_fail_i, .irq_o,
        .link_i, .link_o);
    ipdl_peer u_ipdl_peer (.clock, .rst_n, .fn(peer_fn), .power_low(peer_pl),
        .lat(peer_lat), .kick(peer_kick), .from_dut(link_o), .to_dut(link_i));

    initial forever #20 clock = ~clock;
    // Arbiter and memory: grant follows the request, every access is acked one edge late.
    always @(posedge clock) begin
        dma_gnt_i <= dma_req_o;
        mem_ack_i <= mem_valid_o && !mem_ack_i;
        mem_rdata_i <= 16'hc300 ^ mem_req_o.addr[15:0];
        n_rises <= n_rises + int'(dma_req_o && !dma_gnt_i);
    end
    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One classic cycle; read data lands in q at the ack edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 16'h0000, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 50) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string what);
        wb(1'b0, a, 16'h0000);
        chk(what, exp, q);
    endtask
    // Moves three words at 0x0100 in either direction and polls ready; the count is preloaded negative.
    task automatic xfer(input logic [15:0] ctl, input logic [2:0] pf, input logic [3:0] lat,
                        input int rises);
        int r0;
        int n;
        peer_fn <= pf;
        peer_lat <= lat;
        wb(1'b1, IPDL_ADR_WORD_COUNT, 16'hfffd);
        wb(1'b1, IPDL_ADR_BUS_ADDR, 16'h0101);
        r0 = n_rises;
        wb(1'b1, IPDL_ADR_CTRL, ctl);
        // A receiver waits for the partner's first busy fall to start.
        if (!ctl[8]) begin
            peer_kick <= 1'b1;
            @(posedge clock);
            peer_kick <= 1'b0;
        end
        n = 0;
        do begin
            wb(1'b0, IPDL_ADR_CTRL, 16'h0000);
            n++;
        end while (q[7] !== 1'b1 && n < 200);
        chk("ready", 16'h0001, {15'h0, n < 200});
        if (n >= 200) give_verdict();
        rc(IPDL_ADR_WORD_COUNT, 16'h0000, "count");
        rc(IPDL_ADR_BUS_ADDR, 16'h0106, "address");
        chk("last word", 16'hc204, link_o.data);
        chk("bus requests", 16'(rises), 16'(n_rises - r0));
        $display("test transfer done");
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rc(IPDL_ADR_CTRL, 16'h0080, "ctrl after reset");
        rc(8'h10, 16'h0000, "unmapped");
        peer_fn <= 3'b101;
        wb(1'b1, IPDL_ADR_CTRL, 16'h000a);
        repeat (4) @(posedge clock);
        chk("fn out", 16'h0005, {13'h0, link_o.fn});
        rc(IPDL_ADR_CTRL, 16'h0a8a, "partner status");
        rc(IPDL_ADR_DATA, 16'h5a3c, "partner data");
        $display("test mirror done");
        wb(1'b1, IPDL_ADR_CTRL, 16'h0041);
        peer_fn <= 3'b111;
        repeat (6) @(posedge clock);
        chk("no cycle on go", 16'h0000, {15'h0, dma_req_o});
        rc(IPDL_ADR_CTRL, 16'haec0, "remote interrupt");
        chk("irq", 16'h0001, {15'h0, irq_o});
        wb(1'b1, IPDL_ADR_CTRL, 16'h0040);
        rc(IPDL_ADR_CTRL, 16'haec0, "attention held");
        peer_fn <= 3'b000;
        repeat (6) @(posedge clock);
        wb(1'b1, IPDL_ADR_CTRL, 16'h0040);
        rc(IPDL_ADR_CTRL, 16'h00c0, "attention cleared");
        peer_pl <= 1'b1;
        power_fail_i <= 1'b1;
        repeat (6) @(posedge clock);
        chk("irq on power low", 16'h0001, {15'h0, irq_o});
        chk("power low out", 16'h0001, {15'h0, link_o.power_low});
        peer_pl <= 1'b0;
        power_fail_i <= 1'b0;
        repeat (6) @(posedge clock);
        wb(1'b1, IPDL_ADR_CTRL, 16'h0040);
        repeat (2) @(posedge clock);
        chk("irq cleared", 16'h0000, {15'h0, irq_o});
        wb(1'b1, IPDL_ADR_DATA, 16'h1234);
        repeat (2) @(posedge clock);
        chk("word out", 16'h1234, link_o.data);
        $display("test events done");
        xfer(16'h0109, 3'b101, 4'h6, 3);
        xfer(16'h0101, 3'b001, 4'h1, 1);
        xfer(16'h0003, 3'b100, 4'h2, 3);
        chk("write data", 16'h5a3c, mem_req_o.wdata);
        chk("write access", 16'h0001, {15'h0, mem_req_o.we});
        give_verdict();
    end
endmodule
